// file: core/port0_flow_control_select.sv
// How it works
// - Bit 6 is writable backpressure enable for half duplex.
// - Bit 5 reads duplex in force: 1 half, 0 full.
// - Bit 4 reads receive pause in force, manual or negotiated.
// - Bit 3 reads transmit pause in force.
// - Bit 2 is writable receive pause enable, used when manual or no negotiation.
// - Bit 1 is writable transmit pause enable, used when manual or no negotiation.
// - Select 0 with negotiation on: negotiated result wins, enables ignored.
// - Select 1: enables alone set pause while in full duplex.
// - MAC mode forces select to 1 and makes it read only.
// - MAC mode select defaults 1, untouched by loader rewrites.
// - Writable bits default from straps and follow loader rewrites.
// - Status bits derive from several straps and follow rewrites.
// - Writes never touch the emulated PHY advertisement.
module port0_flow_control_select (
    // Clock and reset
    input  wire logic                      SYS_CLK_I,
    input  wire logic                      SYS_RST_I,
    // Register access
    input  wire fc_sel_pkg::reg_req_t      REG_REQ_I,
    output logic [31:0]                    REG_RDATA_O,
    output logic                           REG_RVALID_O,
    // Straps and loader
    input  wire fc_sel_pkg::strap_set_t    STRAP_I,
    input  wire logic                      LOADER_WR_I,
    input  wire logic                      MAC_MODE_I,
    // Negotiation state
    input  wire fc_sel_pkg::link_state_t   LINK_I,
    // Flow control outputs
    output logic                           BACKPRESSURE_EN_O,
    output logic                           DUPLEX_HALF_O,
    output logic                           RX_PAUSE_O,
    output logic                           TX_PAUSE_O
);
    import fc_sel_pkg::*;

    logic       backpressure_en;
    logic       rx_en;
    logic       tx_en;
    logic       select;
    logic       duplex_strap;
    logic       started;
    logic       hit_wr;
    logic       hit_rd;
    logic       load;
    logic       select_eff;
    logic       res_dup;
    logic       res_rx;
    logic       res_tx;
    logic [31:0] next_rdata;

    // Only this one offset is decoded; every other address belongs to another register.
    function automatic logic is_fc0(input logic [8:0] addr);
        return addr == FC0_OFFSET;
    endfunction

    // Straps are driven by same-clock strap logic, so no synchroniser is used.
    assign hit_wr = REG_REQ_I.wr && is_fc0(REG_REQ_I.addr);
    assign hit_rd = REG_REQ_I.rd && is_fc0(REG_REQ_I.addr);
    // The first clocked cycle after release captures straps; later loads follow the loader.
    assign load   = !started || LOADER_WR_I;
    assign select_eff = MAC_MODE_I ? SELECT_MAC_VAL : select;

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            started <= 1'b0;
        end else begin
            started <= 1'b1;
        end
    end

    // A loader rewrite lands after the software write in the same cycle, since it is newer config.
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            backpressure_en <= 1'b0;
            rx_en           <= 1'b0;
            tx_en           <= 1'b0;
            duplex_strap    <= 1'b0;
        end else if (load) begin
            backpressure_en <= STRAP_I.backpressure;
            rx_en           <= STRAP_I.pause;
            tx_en           <= STRAP_I.pause;
            duplex_strap    <= STRAP_I.duplex_half;
        end else if (hit_wr) begin
            backpressure_en <= REG_REQ_I.wdata[BIT_BP_EN];
            rx_en           <= REG_REQ_I.wdata[BIT_RX_EN];
            tx_en           <= REG_REQ_I.wdata[BIT_TX_EN];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            select <= SELECT_MAC_VAL;
        end else if (MAC_MODE_I) begin
            select <= SELECT_MAC_VAL;
        end else if (load) begin
            select <= STRAP_I.select;
        end else if (hit_wr) begin
            select <= REG_REQ_I.wdata[BIT_SELECT];
        end
    end

    // The advertisement register lives elsewhere and has no path from this block.
    fc_resolve fc_resolve_i (
        .select_i       (select_eff),
        .rx_en_i        (rx_en),
        .tx_en_i        (tx_en),
        .duplex_strap_i (duplex_strap),
        .link_i         (LINK_I),
        .duplex_half_o  (res_dup),
        .rx_pause_o     (res_rx),
        .tx_pause_o     (res_tx)
    );

    always_comb begin
        next_rdata                = 32'h0000_0000;
        next_rdata[BIT_BP_EN]     = backpressure_en;
        next_rdata[BIT_DUPLEX]    = res_dup;
        next_rdata[BIT_RX_STATUS] = res_rx;
        next_rdata[BIT_TX_STATUS] = res_tx;
        next_rdata[BIT_RX_EN]     = rx_en;
        next_rdata[BIT_TX_EN]     = tx_en;
        next_rdata[BIT_SELECT]    = select_eff;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            REG_RDATA_O  <= 32'h0000_0000;
            REG_RVALID_O <= 1'b0;
        end else begin
            REG_RVALID_O <= hit_rd;
            if (hit_rd) begin
                REG_RDATA_O <= next_rdata;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            BACKPRESSURE_EN_O <= 1'b0;
            DUPLEX_HALF_O     <= 1'b0;
            RX_PAUSE_O        <= 1'b0;
            TX_PAUSE_O        <= 1'b0;
        end else begin
            BACKPRESSURE_EN_O <= backpressure_en && res_dup;
            DUPLEX_HALF_O     <= res_dup;
            RX_PAUSE_O        <= res_rx;
            TX_PAUSE_O        <= res_tx;
        end
    end

    chk_mac_select_high: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        MAC_MODE_I && !$past(SYS_RST_I) |=> select) else $error("select not forced in MAC mode");

    chk_write_bp_lands: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        hit_wr && !load |=> backpressure_en == $past(REG_REQ_I.wdata[BIT_BP_EN]))
        else $error("backpressure write lost");

    chk_loader_pause: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        LOADER_WR_I |=> rx_en == $past(STRAP_I.pause) && tx_en == $past(STRAP_I.pause))
        else $error("loader pause strap not applied");

    chk_read_reserved: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        REG_RVALID_O |-> REG_RDATA_O[31:7] == 25'h0) else $error("reserved bits nonzero");

    chk_manual_pause: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        select_eff && !res_dup |=> RX_PAUSE_O == $past(rx_en) && TX_PAUSE_O == $past(tx_en))
        else $error("manual pause not applied");

    chk_auto_pause: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        !select_eff && LINK_I.an_enable && !res_dup |=> RX_PAUSE_O == $past(LINK_I.an_rx_pause))
        else $error("negotiated pause not applied");

    chk_status_bits: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        REG_REQ_I.rd && REG_REQ_I.addr == FC0_OFFSET |=>
        REG_RVALID_O && REG_RDATA_O[5:3] == $past({res_dup, res_rx, res_tx}))
        else $error("status readback wrong");

    chk_half_no_pause: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        res_dup |=> !RX_PAUSE_O && !TX_PAUSE_O) else $error("pause active in half duplex");

    chk_duplex_strap: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        LOADER_WR_I |=> duplex_strap == $past(STRAP_I.duplex_half))
        else $error("duplex strap not applied");

    chk_reset_straps: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        !started |=> backpressure_en == $past(STRAP_I.backpressure)
        && rx_en == $past(STRAP_I.pause))
        else $error("strap defaults not loaded after reset");

    chk_write_rx_lands: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        hit_wr && !load |=> rx_en == $past(REG_REQ_I.wdata[BIT_RX_EN]))
        else $error("receive pause enable write lost");

    chk_write_tx_lands: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        hit_wr && !load |=> tx_en == $past(REG_REQ_I.wdata[BIT_TX_EN]))
        else $error("transmit pause enable write lost");

    chk_write_select: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        hit_wr && !load && !MAC_MODE_I |=> select == $past(REG_REQ_I.wdata[BIT_SELECT]))
        else $error("select write lost");

    chk_loader_bp: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        LOADER_WR_I |=> backpressure_en == $past(STRAP_I.backpressure))
        else $error("loader backpressure strap not applied");

    chk_loader_select: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        LOADER_WR_I && !MAC_MODE_I |=> select == $past(STRAP_I.select))
        else $error("loader select strap not applied");

    chk_mac_loader_keep: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        MAC_MODE_I && LOADER_WR_I |=> select) else $error("loader changed select in MAC mode");

    chk_mac_readback: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        hit_rd && MAC_MODE_I |=> REG_RDATA_O[BIT_SELECT])
        else $error("select reads low in MAC mode");

    chk_auto_tx_pause: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        !select_eff && LINK_I.an_enable && !res_dup |=> TX_PAUSE_O == $past(LINK_I.an_tx_pause))
        else $error("negotiated transmit pause not applied");

    chk_duplex_link: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        LINK_I.an_enable |=> DUPLEX_HALF_O == $past(LINK_I.an_duplex_half))
        else $error("negotiated duplex not applied");

    chk_duplex_fallback: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        !LINK_I.an_enable |=> DUPLEX_HALF_O == $past(duplex_strap))
        else $error("strap duplex not applied");

    chk_bp_half_only: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        !res_dup |=> !BACKPRESSURE_EN_O) else $error("backpressure active in full duplex");

    chk_enable_readback: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        hit_rd |=> REG_RDATA_O[BIT_BP_EN] == $past(backpressure_en)
        && REG_RDATA_O[BIT_RX_EN] == $past(rx_en) && REG_RDATA_O[BIT_TX_EN] == $past(tx_en))
        else $error("enable readback wrong");

endmodule // port0_flow_control_select

// file: core/fc_sel_pkg.sv
package fc_sel_pkg;

    localparam logic [8:0]  FC0_OFFSET     = 9'h1A8;
    localparam int          BIT_BP_EN      = 6;
    localparam int          BIT_DUPLEX     = 5;
    localparam int          BIT_RX_STATUS  = 4;
    localparam int          BIT_TX_STATUS  = 3;
    localparam int          BIT_RX_EN      = 2;
    localparam int          BIT_TX_EN      = 1;
    localparam int          BIT_SELECT     = 0;
    localparam logic [31:0] WRITABLE_MASK  = 32'h0000_0047;
    localparam logic        SELECT_MAC_VAL = 1'b1;

    // Register access request from the device's internal register path.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [8:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;

    // Strap values, as sampled at reset or rewritten by the loader.
    typedef struct packed {
        logic backpressure;
        logic pause;
        logic select;
        logic duplex_half;
    } strap_set_t;

    // Negotiated or forced link state feeding the in-force status bits.
    typedef struct packed {
        logic an_enable;
        logic an_duplex_half;
        logic an_rx_pause;
        logic an_tx_pause;
    } link_state_t;

endpackage

// file: core/fc_resolve.sv
module fc_resolve (
    // Settings
    input  wire logic                      select_i,
    input  wire logic                      rx_en_i,
    input  wire logic                      tx_en_i,
    input  wire logic                      duplex_strap_i,
    input  wire fc_sel_pkg::link_state_t   link_i,
    // Resolved flow control
    output logic                           duplex_half_o,
    output logic                           rx_pause_o,
    output logic                           tx_pause_o
);
    import fc_sel_pkg::*;

    always_comb begin
        duplex_half_o = link_i.an_enable ? link_i.an_duplex_half : duplex_strap_i;
        if (duplex_half_o) begin
            // Pause frames only exist in full duplex.
            rx_pause_o = 1'b0;
            tx_pause_o = 1'b0;
        end else if (!select_i && link_i.an_enable) begin
            rx_pause_o = link_i.an_rx_pause;
            tx_pause_o = link_i.an_tx_pause;
        end else begin
            rx_pause_o = rx_en_i;
            tx_pause_o = tx_en_i;
        end
    end

endmodule // fc_resolve

// file: testbench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fc_sel_pkg::*;

    logic        sys_clk   = 1'b0;
    logic        sys_rst   = 1'b1;
    reg_req_t    reg_req   = '0;
    strap_set_t  strap     = '0;
    link_state_t link      = '0;
    logic        loader_wr = 1'b0;
    logic        mac_mode  = 1'b0;
    logic [31:0] reg_rdata;
    logic        reg_rvalid;
    logic        bp_o;
    logic        dup_o;
    logic        rx_o;
    logic        tx_o;
    logic        m_bp, m_rx, m_tx, m_sel, m_dup;
    logic [31:0] wd;
    logic [8:0]  wa;
    int          fails       = 0;
    int          comparisons = 0;

    port0_flow_control_select port0_flow_control_select_i (
        .SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .REG_REQ_I(reg_req),
        .REG_RDATA_O(reg_rdata), .REG_RVALID_O(reg_rvalid), .STRAP_I(strap),
        .LOADER_WR_I(loader_wr), .MAC_MODE_I(mac_mode), .LINK_I(link),
        .BACKPRESSURE_EN_O(bp_o), .DUPLEX_HALF_O(dup_o), .RX_PAUSE_O(rx_o), .TX_PAUSE_O(tx_o));

    initial forever #2 sys_clk = ~sys_clk;

    task automatic conclude();
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    // Mirrors the strap load; select keeps its value in MAC mode.
    task automatic load_model();
        m_bp  = strap.backpressure;
        m_rx  = strap.pause;
        m_tx  = strap.pause;
        m_dup = strap.duplex_half;
        if (!mac_mode) m_sel = strap.select;
    endtask

    function automatic logic [6:0] expect_word();
        logic sel, half, rx, tx;
        sel  = mac_mode | m_sel;
        half = link.an_enable ? link.an_duplex_half : m_dup;
        rx   = (!sel && link.an_enable) ? link.an_rx_pause : m_rx;
        tx   = (!sel && link.an_enable) ? link.an_tx_pause : m_tx;
        return {m_bp, half, rx & ~half, tx & ~half, m_rx, m_tx, sel};
    endfunction

    task automatic read_reg(input logic [8:0] a, output logic [31:0] d, output logic seen);
        @(negedge sys_clk);
        reg_req.rd   = 1'b1;
        reg_req.addr = a;
        @(negedge sys_clk);
        reg_req.rd = 1'b0;
        seen       = reg_rvalid;
        d          = reg_rdata;
    endtask

    // A loader pulse in the same cycle as a write must win over it.
    task automatic write_reg(input logic [8:0] a, input logic [31:0] d, input logic ld);
        @(negedge sys_clk);
        reg_req.wr    = 1'b1;
        reg_req.addr  = a;
        reg_req.wdata = d;
        loader_wr     = ld;
        @(negedge sys_clk);
        reg_req.wr = 1'b0;
        loader_wr  = 1'b0;
        if (ld) load_model();
        else if (a == FC0_OFFSET) begin
            m_bp = d[6];
            m_rx = d[2];
            m_tx = d[1];
            if (!mac_mode) m_sel = d[0];
        end
    endtask

    task automatic check_all();
        logic [31:0] d;
        logic        seen;
        logic [6:0]  e;
        cyc(3);
        e = expect_word();
        read_reg(FC0_OFFSET, d, seen);
        chk({31'h0, seen}, 32'h1);
        chk(d, {25'h0, e});
        chk({28'h0, bp_o, dup_o, rx_o, tx_o}, {28'h0, e[6] & e[5], e[5:3]});
        read_reg(FC0_OFFSET ^ 9'h004, d, seen);
        chk({31'h0, seen}, 32'h0);
    endtask

    initial begin
        #200000;
        fails++;
        conclude();
    end

    initial begin
        void'($urandom(80));
        strap = strap_set_t'(4'($urandom));
        m_sel = 1'b1;
        cyc(3);
        sys_rst = 1'b0;
        load_model();
        check_all();
        for (int i = 0; i < 60; i++) begin
            link = link_state_t'(4'($urandom));
            wd   = (i < 2) ? {32{i[0]}} : $urandom;
            wa   = ($urandom % 4 == 0) ? 9'($urandom) : FC0_OFFSET;
            case ($urandom % 3)
                0: begin
                    strap = strap_set_t'(4'($urandom));
                    write_reg(FC0_OFFSET, wd, 1'b1);
                end
                default: write_reg(wa, wd, 1'b0);
            endcase
            check_all();
        end
        // MAC mode pins select high whatever software or the loader try.
        mac_mode = 1'b1;
        write_reg(FC0_OFFSET, 32'h0000_0006, 1'b0);
        check_all();
        strap = strap_set_t'(4'hD);
        write_reg(FC0_OFFSET, 32'h0, 1'b1);
        check_all();
        conclude();
    end
endmodule // tb
